// ### inc/eeslv_regs.svh
// register offsets, field positions, reset values and timing counts of the eeprom slave front end
`ifndef EESLV_REGS_SVH
`define EESLV_REGS_SVH

`define EESLV_OFF_CTRL 8'h00
`define EESLV_OFF_STATUS 8'h04
`define EESLV_OFF_ADDR 8'h08

`define EESLV_CTRL_EN_BIT 0
`define EESLV_CTRL_RST 1'b1

`define EESLV_STAT_STATE_LSB 0
`define EESLV_STAT_STATE_MSB 6
`define EESLV_STAT_PROT_BIT 8
`define EESLV_STAT_WP_BIT 9
`define EESLV_STAT_BUSY_BIT 10

`define EESLV_SYNC_RST 3'h3
`define EESLV_BITS_PER_BYTE 4'h8
`define EESLV_LAST_TX_BIT 4'h7

`define EESLV_TWR_MS 10
`define EESLV_CLK_KHZ 50000

`endif

// ### inc/eeslv_pkg.sv
// types shared by the eeprom slave front end
package eeslv_pkg;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_RX    = 7'h02,
		ST_ACK   = 7'h04,
		ST_TX    = 7'h08,
		ST_MACK  = 7'h10,
		ST_WAIT  = 7'h20,
		ST_WRCYC = 7'h40
	} eeslv_st_t;

	typedef enum logic [1:0] {
		R_DEV  = 2'h0,
		R_ARR  = 2'h1,
		R_DATA = 2'h2,
		R_RD   = 2'h3
	} eeslv_role_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} eeslv_wb_req_t;

	typedef struct packed {
		logic wr;
		logic [10:0] addr;
		logic [7:0] wdata;
	} eeslv_mem_t;

	typedef struct packed {
		logic [2:0] meta;
		logic [2:0] sync;
	} eeslv_sync_st_t;

	typedef struct packed {
		eeslv_st_t st;
		eeslv_role_t role;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [10:0] addr;
		logic rw;
		logic wrote;
		logic mack;
		logic oe_n;
		logic scl_p;
		logic sda_p;
		logic [19:0] twr;
		logic enable;
		logic prot_hit;
		eeslv_mem_t mem;
		logic wb_ack;
		logic [31:0] wb_dat;
	} eeslv_top_st_t;

endpackage

// ### rtl/eeslv_sync.sv
// two-flop synchroniser for the bus clock, bus data and write-protect pins
`include "eeslv_regs.svh"

module eeslv_sync (
	input logic i_clk,
	input logic i_reset,
	input logic [2:0] i_async,
	output logic [2:0] o_sync
);

	eeslv_pkg::eeslv_sync_st_t r;
	eeslv_pkg::eeslv_sync_st_t n;

	// first stage feeds only the second stage
	always_comb begin
		n = r;
		n.meta = i_async;
		n.sync = r.meta;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			r.meta <= `EESLV_SYNC_RST;
			r.sync <= `EESLV_SYNC_RST;
		end else begin
			r <= n;
		end
	end

	assign o_sync = r.sync;

endmodule

// ### rtl/eeslv_top.sv
// two-wire slave front end of a 16 kbit serial eeprom with a wishbone status port
`include "eeslv_regs.svh"

module eeslv_top #(
	parameter int P_TWR_CYCLES = `EESLV_TWR_MS * `EESLV_CLK_KHZ,
	// device type code: value is arbitrary
	parameter logic [3:0] P_DEV_TYPE = 4'h5
) (
	input logic i_clk,
	input logic i_reset,
	input logic i_scl,
	input logic i_sda_i,
	output logic o_sda_o,
	output logic o_sda_oe_n,
	input logic i_wp,
	input eeslv_pkg::eeslv_wb_req_t i_wb,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output eeslv_pkg::eeslv_mem_t o_mem,
	input logic [7:0] i_mem_rdata
);

	eeslv_pkg::eeslv_top_st_t r;
	eeslv_pkg::eeslv_top_st_t n;
	logic [2:0] pins_s;
	logic s_scl;
	logic s_sda;
	logic s_wp;
	logic ev_rise;
	logic ev_fall;
	logic ev_start;
	logic ev_stop;
	logic byte_end;
	logic wr_access;
	logic hit_clear;

	// the pull-down lives in the pad; an open pin arrives here as low
	eeslv_sync u_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_async({i_wp, i_sda_i, i_scl}),
		.o_sync(pins_s)
	);

	assign s_scl = pins_s[0];
	assign s_sda = pins_s[1];
	assign s_wp = pins_s[2];

	// edges seen on the system clock; glitches shorter than one cycle may slip through
	assign ev_rise = !r.scl_p && s_scl;
	assign ev_fall = r.scl_p && !s_scl;
	assign ev_start = r.scl_p && s_scl && r.sda_p && !s_sda;
	assign ev_stop = r.scl_p && s_scl && !r.sda_p && s_sda;
	assign byte_end = (r.st == eeslv_pkg::ST_RX) && ev_fall && (r.cnt == `EESLV_BITS_PER_BYTE);
	assign wr_access = !(s_wp && r.addr[10]);
	assign hit_clear = i_wb.cyc && i_wb.stb && !r.wb_ack && i_wb.we && (i_wb.adr == `EESLV_OFF_STATUS)
		&& i_wb.sel[1] && i_wb.dat[`EESLV_STAT_PROT_BIT];

	always_comb begin
		n = r;
		n.scl_p = s_scl;
		n.sda_p = s_sda;
		n.wb_ack = 1'b0;
		n.mem.wr = 1'b0;
		n.mem.addr = r.addr;

		// wishbone slave: one wait-free answer per request, ack dropped after one cycle
		if (i_wb.cyc && i_wb.stb && !r.wb_ack) begin
			n.wb_ack = 1'b1;
			n.wb_dat = 32'h0000_0000;
			if (i_wb.adr == `EESLV_OFF_CTRL) begin
				if (i_wb.we && i_wb.sel[0]) begin
					n.enable = i_wb.dat[`EESLV_CTRL_EN_BIT];
				end
				n.wb_dat[`EESLV_CTRL_EN_BIT] = r.enable;
			end else if (i_wb.adr == `EESLV_OFF_STATUS) begin
				if (i_wb.we && i_wb.sel[1] && i_wb.dat[`EESLV_STAT_PROT_BIT]) begin
					n.prot_hit = 1'b0;
				end
				n.wb_dat[`EESLV_STAT_STATE_MSB:`EESLV_STAT_STATE_LSB] = r.st;
				n.wb_dat[`EESLV_STAT_PROT_BIT] = r.prot_hit;
				n.wb_dat[`EESLV_STAT_WP_BIT] = s_wp;
				n.wb_dat[`EESLV_STAT_BUSY_BIT] = (r.st == eeslv_pkg::ST_WRCYC);
			end else if (i_wb.adr == `EESLV_OFF_ADDR) begin
				n.wb_dat[10:0] = r.addr;
			end
		end

		// link side; a protect hit below is set after the clear above, so the set wins
		if (r.st == eeslv_pkg::ST_WRCYC) begin
			// bus is deaf while the array programs
			if (r.twr == 20'(P_TWR_CYCLES - 1)) begin
				n.st = eeslv_pkg::ST_IDLE;
				n.twr = 20'h0_0000;
			end else begin
				n.twr = r.twr + 20'h0_0001;
			end
		end else if (ev_start && r.enable) begin
			n.st = eeslv_pkg::ST_RX;
			n.role = eeslv_pkg::R_DEV;
			n.cnt = 4'h0;
			n.oe_n = 1'b1;
			n.wrote = 1'b0;
		end else if (ev_stop) begin
			n.oe_n = 1'b1;
			n.twr = 20'h0_0000;
			n.wrote = 1'b0;
			n.st = r.wrote ? eeslv_pkg::ST_WRCYC : eeslv_pkg::ST_IDLE;
		end else begin
			case (r.st)
				eeslv_pkg::ST_RX: begin
					if (ev_rise && (r.cnt != `EESLV_BITS_PER_BYTE)) begin
						n.shreg = {r.shreg[6:0], s_sda};
						n.cnt = r.cnt + 4'h1;
					end else if (byte_end) begin
						case (r.role)
							eeslv_pkg::R_DEV: begin
								if (r.shreg[7:4] == P_DEV_TYPE) begin
									n.addr[10:8] = r.shreg[3:1];
									n.rw = r.shreg[0];
									n.role = r.shreg[0] ? eeslv_pkg::R_RD : eeslv_pkg::R_ARR;
									n.st = eeslv_pkg::ST_ACK;
									n.oe_n = 1'b0;
								end else begin
									n.st = eeslv_pkg::ST_WAIT;
								end
							end
							eeslv_pkg::R_ARR: begin
								n.addr[7:0] = r.shreg;
								n.role = eeslv_pkg::R_DATA;
								n.st = eeslv_pkg::ST_ACK;
								n.oe_n = 1'b0;
							end
							eeslv_pkg::R_DATA: begin
								if (wr_access) begin
									n.mem.wr = 1'b1;
									n.mem.wdata = r.shreg;
									// pointer wraps inside the 16-byte page
									n.addr = {r.addr[10:4], 4'(r.addr[3:0] + 4'h1)};
									n.wrote = 1'b1;
									n.st = eeslv_pkg::ST_ACK;
									n.oe_n = 1'b0;
								end else begin
									n.prot_hit = 1'b1;
									n.st = eeslv_pkg::ST_WAIT;
								end
							end
							default: begin
								n.st = eeslv_pkg::ST_WAIT;
							end
						endcase
					end
				end
				eeslv_pkg::ST_ACK: begin
					// ninth clock ends on its falling edge; line goes back to the transmitter
					if (ev_fall) begin
						n.cnt = 4'h0;
						if (r.role == eeslv_pkg::R_RD) begin
							n.st = eeslv_pkg::ST_TX;
							n.shreg = i_mem_rdata;
							n.oe_n = i_mem_rdata[7];
						end else begin
							n.st = eeslv_pkg::ST_RX;
							n.oe_n = 1'b1;
						end
					end
				end
				eeslv_pkg::ST_TX: begin
					if (ev_fall) begin
						if (r.cnt == `EESLV_LAST_TX_BIT) begin
							n.oe_n = 1'b1;
							n.st = eeslv_pkg::ST_MACK;
						end else begin
							n.cnt = r.cnt + 4'h1;
							n.shreg = {r.shreg[6:0], 1'b0};
							n.oe_n = r.shreg[6];
						end
					end
				end
				eeslv_pkg::ST_MACK: begin
					if (ev_rise) begin
						n.mack = !s_sda;
						if (!s_sda) begin
							n.addr = r.addr + 11'h001;
						end
					end else if (ev_fall) begin
						n.cnt = 4'h0;
						if (r.mack) begin
							n.st = eeslv_pkg::ST_TX;
							n.shreg = i_mem_rdata;
							n.oe_n = i_mem_rdata[7];
						end else begin
							n.st = eeslv_pkg::ST_WAIT;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			r <= '0;
			r.st <= eeslv_pkg::ST_IDLE;
			r.role <= eeslv_pkg::R_DEV;
			r.oe_n <= 1'b1;
			r.scl_p <= 1'b1;
			r.sda_p <= 1'b1;
			r.enable <= `EESLV_CTRL_RST;
		end else begin
			r <= n;
		end
	end

	assign o_sda_o = 1'b0;
	assign o_sda_oe_n = r.oe_n;
	assign o_wb_dat = r.wb_dat;
	assign o_wb_ack = r.wb_ack;
	assign o_mem = r.mem;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_dev_match;
		byte_end && (r.role == eeslv_pkg::R_DEV) && (r.shreg[7:4] == P_DEV_TYPE);
	endsequence

	sequence s_dev_miss;
		byte_end && (r.role == eeslv_pkg::R_DEV) && (r.shreg[7:4] != P_DEV_TYPE);
	endsequence

	sequence s_data_byte;
		byte_end && (r.role == eeslv_pkg::R_DATA);
	endsequence

	sequence s_ack_ends;
		(r.st == eeslv_pkg::ST_ACK) && ev_fall && (r.role != eeslv_pkg::R_RD) && !ev_start && !ev_stop;
	endsequence

	a_addr_acked: assert property (s_dev_match |=> (r.st == eeslv_pkg::ST_ACK) && !o_sda_oe_n
		&& (r.addr[10:8] == $past(r.shreg[3:1])))
		else $error("matching slave address not acknowledged");

	a_type_miss: assert property (s_dev_miss |=> (r.st == eeslv_pkg::ST_WAIT) && o_sda_oe_n)
		else $error("mismatched slave address answered");

	a_rw_decode: assert property (s_dev_match |=>
		(r.role == ($past(r.shreg[0]) ? eeslv_pkg::R_RD : eeslv_pkg::R_ARR)))
		else $error("read/write bit decoded wrongly");

	a_wp_refuse: assert property (s_data_byte and (s_wp && r.addr[10]) |=>
		(r.st == eeslv_pkg::ST_WAIT) && !o_mem.wr && o_sda_oe_n && r.prot_hit)
		else $error("protected write accepted");

	a_wp_allow: assert property (s_data_byte and !s_wp |=> o_mem.wr
		&& (o_mem.addr == $past(r.addr)) && (o_mem.wdata == $past(r.shreg)) && !o_sda_oe_n)
		else $error("unprotected write lost");

	a_page_roll: assert property (o_mem.wr |-> (r.addr[10:4] == o_mem.addr[10:4])
		&& (r.addr[3:0] == 4'(o_mem.addr[3:0] + 4'h1)))
		else $error("write pointer left its page");

	a_open_drain: assert property (!o_sda_oe_n |->
		(r.st == eeslv_pkg::ST_ACK) || (r.st == eeslv_pkg::ST_TX))
		else $error("data line pulled outside ack or send");

	a_ack_release: assert property (s_ack_ends |=> o_sda_oe_n && (r.st == eeslv_pkg::ST_RX))
		else $error("ack not released after ninth clock");

	a_nack_wait: assert property ((r.st == eeslv_pkg::ST_MACK) && ev_fall && !r.mack
		&& !ev_start && !ev_stop |=> (r.st == eeslv_pkg::ST_WAIT) ##1 o_sda_oe_n)
		else $error("sending continued after master nack");

	a_wrcyc_quiet: assert property ((r.st == eeslv_pkg::ST_WRCYC) |-> o_sda_oe_n
		&& !o_mem.wr)
		else $error("bus answered during write cycle");

	a_start_arm: assert property (ev_start && r.enable && (r.st != eeslv_pkg::ST_WRCYC) |=>
		(r.st == eeslv_pkg::ST_RX) && (r.cnt == 4'h0) && (r.role == eeslv_pkg::R_DEV))
		else $error("start did not rearm address phase");

	a_stop_idle: assert property (ev_stop && !r.wrote && (r.st != eeslv_pkg::ST_WRCYC) |=>
		(r.st == eeslv_pkg::ST_IDLE) && o_sda_oe_n)
		else $error("stop did not return to idle");

	a_wrcyc_enter: assert property (ev_stop && r.wrote && (r.st != eeslv_pkg::ST_WRCYC) |=>
		(r.st == eeslv_pkg::ST_WRCYC) && (r.twr == 20'h0_0000))
		else $error("write stop did not start the write cycle");

	a_wrcyc_end: assert property ((r.st == eeslv_pkg::ST_WRCYC) && (r.twr == 20'(P_TWR_CYCLES - 1)) |=>
		(r.st == eeslv_pkg::ST_IDLE))
		else $error("write cycle did not end on time");

	a_cnt_range: assert property ((r.st == eeslv_pkg::ST_RX) |-> (r.cnt <= `EESLV_BITS_PER_BYTE))
		else $error("bit counter ran past one byte");

	a_read_load: assert property ((r.st == eeslv_pkg::ST_ACK) && ev_fall
		&& (r.role == eeslv_pkg::R_RD) |=> (r.st == eeslv_pkg::ST_TX) && (o_sda_oe_n == $past(i_mem_rdata[7])))
		else $error("read byte not loaded after address ack");

	a_tx_shift: assert property ((r.st == eeslv_pkg::ST_TX) && ev_fall
		&& (r.cnt != `EESLV_LAST_TX_BIT) |=> (o_sda_oe_n == $past(r.shreg[6])))
		else $error("next read bit not driven");

	a_tx_release: assert property ((r.st == eeslv_pkg::ST_TX) && ev_fall
		&& (r.cnt == `EESLV_LAST_TX_BIT) |=> o_sda_oe_n && (r.st == eeslv_pkg::ST_MACK))
		else $error("data line held after eighth read bit");

	a_mack_addr: assert property ((r.st == eeslv_pkg::ST_MACK) && ev_rise && !s_sda |=>
		(r.addr == 11'($past(r.addr) + 11'h001)))
		else $error("read pointer not advanced on master ack");

	a_wb_answer: assert property (i_wb.cyc && i_wb.stb && !o_wb_ack |=> o_wb_ack)
		else $error("bus request not answered");

	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("bus ack longer than one cycle");

	a_hit_hold: assert property (r.prot_hit && !hit_clear |=> r.prot_hit)
		else $error("protect hit lost without a clear");

	a_hit_clear: assert property (hit_clear
		&& !(byte_end && (r.role == eeslv_pkg::R_DATA) && !wr_access) |=> !r.prot_hit)
		else $error("protect hit not cleared by software");

endmodule

// ### testbench/eeslv_master.sv
// two-wire bus master model: drives the serial clock and pulls the data line
module eeslv_master (
	input logic i_clk,
	input logic i_sda,
	output logic o_scl,
	output logic o_pull
);
	timeunit 1ns;
	timeprecision 1ps;
	// clock stands high between frames, data released to the pull-up
	initial begin
		o_scl = 1'b1;
		o_pull = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// also serves as repeated start
	task automatic start();
		w(1);
		o_pull <= 1'b0;
		w(2);
		o_scl <= 1'b1;
		w(4);
		o_pull <= 1'b1;
		w(4);
		o_scl <= 1'b0;
	endtask
	task automatic stop();
		w(2);
		o_pull <= 1'b1;
		w(3);
		o_scl <= 1'b1;
		w(4);
		o_pull <= 1'b0;
		w(4);
	endtask
	// data moves two cycles after the fall, only while the clock is low
	task automatic bit_tx(input logic b);
		w(2);
		o_pull <= !b;
		w(3);
		o_scl <= 1'b1;
		w(3);
		o_scl <= 1'b0;
	endtask
	task automatic bit_rx(output logic b);
		w(2);
		o_pull <= 1'b0;
		w(3);
		o_scl <= 1'b1;
		w(2);
		b = i_sda;
		w(1);
		o_scl <= 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) bit_tx(d[i]);
		bit_rx(b);
		ack = !b;
	endtask
	// master is receiver on reads and may withhold its ack
	task automatic rbyte(input logic ack, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) bit_rx(d[i]);
		bit_tx(!ack);
	endtask
endmodule

// ### testbench/test_eeslv_top.sv
// self-checking bench of the eeprom slave front end
module test_eeslv_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TWR = 200;
	// device type code: value is arbitrary
	localparam logic [3:0] DEVT = 4'h5;
	logic clk = 1'b0, rst = 1'b1, wp = 1'b0, scl, pull, sda, sda_o, oe_n, ack_o, a;
	logic [31:0] wbdat, r;
	eeslv_pkg::eeslv_wb_req_t wb = '0;
	eeslv_pkg::eeslv_mem_t mem;
	logic [7:0] rdata, d, arr;
	logic [7:0] mem_m [2048];
	logic [18:0] exp_q [$];
	logic [2:0] blk;
	int failures = 0, check_count = 0, cyc_n = 0;
	always #10 clk = ~clk;
	// wire-and of both open-drain parties over a pull-up
	assign sda = !(pull | !oe_n);
	assign rdata = mem_m[mem.addr];
	eeslv_top #(.P_TWR_CYCLES(TWR), .P_DEV_TYPE(DEVT)) u_eeslv_top (.i_clk(clk), .i_reset(rst), .i_scl(scl),
		.i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe_n(oe_n), .i_wp(wp), .i_wb(wb), .o_wb_dat(wbdat),
		.o_wb_ack(ack_o), .o_mem(mem), .i_mem_rdata(rdata));
	eeslv_master u_master (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic sw(input logic [7:0] b, input logic e);
		u_master.wbyte(b, a);
		chk("ack", 32'(e), 32'(a));
		chk("pin drive", 0, 32'(sda_o));
	endtask
	task automatic sel(input logic [2:0] b, input logic rw, input logic e);
		u_master.start();
		sw({DEVT, b, rw}, e);
	endtask
	task automatic wbt(input logic w_en, input logic [7:0] ad, input logic [31:0] dt);
		@(posedge clk);
		wb <= '{cyc: 1'b1, stb: 1'b1, we: w_en, adr: ad, sel: 4'hf, dat: dt};
		// only the ack or the bench timeout ends this wait
		do begin
			@(posedge clk);
		end while (ack_o !== 1'b1);
		r = wbdat;
		wb <= '0;
	endtask
	// every array write must match the model's next expected write
	always @(posedge clk) begin
		cyc_n++;
		if (mem.wr === 1'b1) begin
			if (exp_q.size() == 0) chk("unexpected write", 0, 1);
			else chk("array write", 32'(exp_q.pop_front()), 32'({mem.addr, mem.wdata}));
		end
		if (cyc_n > 20000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		r = $urandom(57868);
		for (int i = 0; i < 2048; i++) mem_m[i] = 8'($urandom);
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		wbt(0, 8'h00, 0);
		chk("ctrl reset", 1, r[0]);
		wbt(0, 8'h0c, 0);
		chk("unmapped", 0, r);
		$display("test registers done");
		// two bytes from the last page slot: the second rolls to the page start
		blk = 3'($urandom);
		arr = {4'($urandom), 4'hf};
		d = 8'($urandom);
		sel(blk, 1'b0, 1'b1);
		sw(arr, 1);
		for (int i = 0; i < 2; i++) begin
			exp_q.push_back({blk, arr[7:4], 4'(arr[3:0] + i), 8'(d + i)});
			mem_m[{blk, arr[7:4], 4'(arr[3:0] + i)}] = 8'(d + i);
			sw(8'(d + i), 1);
		end
		u_master.stop();
		wbt(0, 8'h04, 0);
		chk("busy", 1, r[10]);
		chk("busy state", 32'h0000_0040, r[6:0]);
		sel(blk, 1'b0, 1'b0);
		u_master.stop();
		repeat (TWR) @(posedge clk);
		$display("test page write done");
		sel(blk, 1'b0, 1'b1);
		u_master.start();
		sw({DEVT ^ 4'(1 + $urandom % 15), blk, 1'b0}, 0);
		sw(8'h00, 0);
		u_master.stop();
		$display("test type mismatch done");
		// read across a block boundary, then withhold the ack
		sel(blk, 1'b0, 1'b1);
		sw(8'hff, 1);
		sel(blk, 1'b1, 1'b1);
		u_master.rbyte(1, d);
		chk("read byte", 32'(mem_m[{blk, 8'hff}]), 32'(d));
		u_master.rbyte(0, d);
		chk("read next", 32'(mem_m[11'({blk, 8'hff} + 1)]), 32'(d));
		chk("released", 1, 32'(oe_n));
		u_master.stop();
		wbt(0, 8'h08, 0);
		chk("byte pointer", 32'(11'({blk, 8'hff} + 1)), r);
		$display("test read done");
		wp <= 1'b1;
		blk = {1'b1, 2'($urandom)};
		sel(blk, 1'b0, 1'b1);
		sw(8'($urandom), 1);
		sw(8'($urandom), 0);
		u_master.stop();
		wbt(0, 8'h04, 0);
		chk("protect hit", 3, r[9:8]);
		chk("idle state", 32'h0000_0001, r[6:0]);
		wbt(1, 8'h04, 32'h0000_0100);
		wbt(0, 8'h04, 0);
		chk("hit cleared", 0, r[8]);
		blk[2] = 1'b0;
		arr = 8'($urandom);
		d = 8'($urandom);
		exp_q.push_back({blk, arr, d});
		sel(blk, 1'b0, 1'b1);
		sw(arr, 1);
		sw(d, 1);
		u_master.stop();
		repeat (TWR) @(posedge clk);
		$display("test protect done");
		wbt(1, 8'h00, 0);
		sel(blk, 1'b0, 1'b0);
		u_master.stop();
		wbt(1, 8'h00, 32'h0000_0001);
		chk("writes left", 0, exp_q.size());
		$display("test disable done");
		print_verdict();
	end
endmodule
